// file: hw/repeater_consts.svh
// Constants for the repeater enable controller
`ifndef REPEATER_CONSTS_SVH
`define REPEATER_CONSTS_SVH

`define CLK_PERIOD_NS    25
`define EN_HOLD_NS       130
`define EN_HOLD_CYC      ((`EN_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W       4
`define IDLE_LINK_CYC    8
`define IDLE_CNT_W       8

`endif

// file: hw/repeater_pkg.sv
// Types for the repeater enable controller
package repeater_pkg;
    typedef enum logic [0:0] {
        ST_STEADY,
        ST_SETTLE
    } ctrl_state_t;
endpackage : repeater_pkg

// file: hw/bus_idle_mon.sv
// Segment idle monitor on the link clock
`timescale 1ns/100ps
`include "repeater_consts.svh"
module bus_idle_mon #(
    parameter int IDLE_CYC = `IDLE_LINK_CYC
) (
    input  wire logic link_clk_in,  // Link sampling clock
    input  wire logic link_rst_in,  // Reset, link domain
    input  wire logic data_in,      // Data line level
    input  wire logic clock_in,     // Clock line level
    output logic      idle_out      // Segment idle, registered
);
    if (IDLE_CYC < 1 || IDLE_CYC > ((1 << `IDLE_CNT_W) - 1)) begin : g_bad_idle
        $error("IDLE_CYC out of range");
    end

    logic                   d_s1_r, d_s2_r, d_p_r, c_s1_r, c_s2_r, c_p_r;
    logic                   busy_r, busy_nxt, idle_r, idle_nxt;
    logic [`IDLE_CNT_W-1:0] cnt_r, cnt_nxt;
    logic                   start_det, stop_det;

    always_comb begin
        start_det = c_s2_r && c_p_r && d_p_r && !d_s2_r;
        stop_det  = c_s2_r && c_p_r && !d_p_r && d_s2_r;
        busy_nxt  = busy_r;
        if (start_det) begin
            busy_nxt = 1'b1;
        end else if (stop_det) begin
            busy_nxt = 1'b0;
        end
        cnt_nxt = cnt_r;
        // Any low restarts the free-time count, covering a start missed at reset
        if (!d_s2_r || !c_s2_r) begin
            cnt_nxt = '0;
        end else if (cnt_r != IDLE_CYC[`IDLE_CNT_W-1:0]) begin
            cnt_nxt = cnt_r + `IDLE_CNT_W'(1);
        end
        idle_nxt = !busy_nxt && (cnt_nxt == IDLE_CYC[`IDLE_CNT_W-1:0]);
    end

    always_ff @(posedge link_clk_in) begin
        d_s1_r <= data_in;
        d_s2_r <= d_s1_r;
        c_s1_r <= clock_in;
        c_s2_r <= c_s1_r;
        if (link_rst_in) begin
            d_p_r  <= 1'b1;
            c_p_r  <= 1'b1;
            busy_r <= 1'b1;
            cnt_r  <= '0;
            idle_r <= 1'b0;
        end else begin
            d_p_r  <= d_s2_r;
            c_p_r  <= c_s2_r;
            busy_r <= busy_nxt;
            cnt_r  <= cnt_nxt;
            idle_r <= idle_nxt;
        end
    end

    assign idle_out = idle_r;
endmodule : bus_idle_mon

// file: hw/repeater_ctrl.sv
// Host controller that drives the repeater enable pin safely
`timescale 1ns/100ps
`include "repeater_consts.svh"
module repeater_ctrl #(
    parameter int HOLD_CYC = `EN_HOLD_CYC,
    parameter int IDLE_CYC = `IDLE_LINK_CYC
) (
    input  wire logic clk_in,               // System clock, 40 MHz
    input  wire logic srst_in,              // Synchronous reset, active high
    input  wire logic link_clk_in,          // Bus sampling clock
    input  wire logic enable_req_in,        // Request segments joined
    input  wire logic fast_mode_in,         // 400 kHz needed on the near segment
    input  wire logic bus0_data_in,         // Segment 0 data line level
    input  wire logic bus0_clock_in,        // Segment 0 clock line level
    input  wire logic bus1_data_in,         // Segment 1 data line level
    input  wire logic bus1_clock_in,        // Segment 1 clock line level
    output logic      repeater_enable_out,  // To repeater enable pin
    output logic      bus_idle_out          // Both segments idle
);
    // Counter widths bound the legal settings
    if (HOLD_CYC < 1 || HOLD_CYC > ((1 << `HOLD_CNT_W) - 1)) begin : g_bad_hold
        $error("HOLD_CYC out of range");
    end
    if (IDLE_CYC < 1 || IDLE_CYC > ((1 << `IDLE_CNT_W) - 1)) begin : g_bad_idle
        $error("IDLE_CYC out of range");
    end

    // Link-domain reset, two stages
    logic lrst_s1_r, lrst_s2_r;
    always_ff @(posedge link_clk_in) begin
        lrst_s1_r <= srst_in;
        lrst_s2_r <= lrst_s1_r;
    end

    // One monitor per segment; neither side is preferred
    logic idle0_l, idle1_l;
    bus_idle_mon #(.IDLE_CYC(IDLE_CYC)) u_mon0 (
        .link_clk_in (link_clk_in),
        .link_rst_in (lrst_s2_r),
        .data_in     (bus0_data_in),
        .clock_in    (bus0_clock_in),
        .idle_out    (idle0_l)
    );
    bus_idle_mon #(.IDLE_CYC(IDLE_CYC)) u_mon1 (
        .link_clk_in (link_clk_in),
        .link_rst_in (lrst_s2_r),
        .data_in     (bus1_data_in),
        .clock_in    (bus1_clock_in),
        .idle_out    (idle1_l)
    );

    // Idle levels into the system domain
    logic idle0_s1_r, idle0_s2_r, idle1_s1_r, idle1_s2_r;
    logic idle_both_r, idle_both_nxt;
    always_ff @(posedge clk_in) begin
        idle0_s1_r <= idle0_l;
        idle0_s2_r <= idle0_s1_r;
        idle1_s1_r <= idle1_l;
        idle1_s2_r <= idle1_s1_r;
    end

    repeater_pkg::ctrl_state_t   state_r, state_nxt;
    logic [`HOLD_CNT_W-1:0]      cnt_r, cnt_nxt;
    logic                        en_r, en_nxt;
    logic                        want;

    always_comb begin
        idle_both_nxt = idle0_s2_r && idle1_s2_r;
        // Fast mode overrides the request so the slow segment drops out
        want      = enable_req_in && !fast_mode_in;
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        en_nxt    = en_r;
        unique case (state_r)
            repeater_pkg::ST_STEADY: begin
                cnt_nxt = '0;
                if (want != en_r && idle_both_r) begin
                    state_nxt = repeater_pkg::ST_SETTLE;
                end
            end
            repeater_pkg::ST_SETTLE: begin
                // Abort if traffic starts or the wish flips back during hold
                if (!idle_both_r || want == en_r) begin
                    state_nxt = repeater_pkg::ST_STEADY;
                end else if (cnt_r == HOLD_CYC[`HOLD_CNT_W-1:0] - `HOLD_CNT_W'(1)) begin
                    en_nxt    = want;
                    state_nxt = repeater_pkg::ST_STEADY;
                end else begin
                    cnt_nxt = cnt_r + `HOLD_CNT_W'(1);
                end
            end
        endcase
    end

    // Reset isolates: segment state is unknown until a stop and then free time are seen
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r     <= repeater_pkg::ST_STEADY;
            cnt_r       <= '0;
            en_r        <= 1'b0;
            idle_both_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            en_r        <= en_nxt;
            idle_both_r <= idle_both_nxt;
        end
    end

    // One enable line serves exactly one repeater
    assign repeater_enable_out = en_r;
    assign bus_idle_out        = idle_both_r;

    // Cycles since the last enable change, saturating at the hold; read by checks only
    logic [`HOLD_CNT_W-1:0] gap_r, gap_nxt;
    always_comb begin
        gap_nxt = gap_r;
        if (en_nxt != en_r) begin
            gap_nxt = '0;
        end else if (gap_r != `HOLD_CNT_W'(HOLD_CYC)) begin
            gap_nxt = gap_r + `HOLD_CNT_W'(1);
        end
    end

    // Reset counts as a long quiet time, so the first change is not held back
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            gap_r <= `HOLD_CNT_W'(HOLD_CYC);
        end else begin
            gap_r <= gap_nxt;
        end
    end

    property p_change_idle;
        @(posedge clk_in) disable iff (srst_in)
        $changed(en_r) |-> $past(idle_both_r);
    endproperty
    a_change_idle: assert property (p_change_idle) else $error("Enable changed while busy");

    // Idle must have stood one cycle and HOLD_CYC cycles before the deciding cycle
    property p_change_hold;
        @(posedge clk_in) disable iff (srst_in)
        $changed(en_r) |-> $past(idle_both_r, HOLD_CYC + 1) && $past(idle_both_r, 2);
    endproperty
    a_change_hold: assert property (p_change_hold) else $error("Enable changed without hold");

    property p_fast_iso;
        @(posedge clk_in) disable iff (srst_in)
        (fast_mode_in && idle_both_r)[*8] |-> !en_r;
    endproperty
    a_fast_iso: assert property (p_fast_iso) else $error("Fast mode left segment joined");

    property p_either_busy;
        @(posedge clk_in) disable iff (srst_in)
        (!idle0_s2_r || !idle1_s2_r) ##1 !idle_both_r |=> !$changed(en_r);
    endproperty
    a_either_busy: assert property (p_either_busy) else $error("Busy segment ignored");

    property p_reset_iso;
        @(posedge clk_in)
        srst_in |=> !en_r && !idle_both_r;
    endproperty
    a_reset_iso: assert property (p_reset_iso) else $error("Reset left segments joined");

    property p_change_gap;
        @(posedge clk_in) disable iff (srst_in)
        (en_nxt != en_r) |-> (gap_r == `HOLD_CNT_W'(HOLD_CYC));
    endproperty
    a_change_gap: assert property (p_change_gap)
        else $error("Enable changes too close together");

    property p_change_settled;
        @(posedge clk_in) disable iff (srst_in)
        $changed(en_r) |-> $past(state_r == repeater_pkg::ST_SETTLE);
    endproperty
    a_change_settled: assert property (p_change_settled)
        else $error("Enable changed outside settle");

    property p_settle_bound;
        @(posedge clk_in) disable iff (srst_in)
        state_r == repeater_pkg::ST_SETTLE |-> cnt_r < `HOLD_CNT_W'(HOLD_CYC);
    endproperty
    a_settle_bound: assert property (p_settle_bound)
        else $error("Settle count overran hold");

    property p_settle_abort;
        @(posedge clk_in) disable iff (srst_in)
        state_r == repeater_pkg::ST_SETTLE && !idle_both_r |=> state_r == repeater_pkg::ST_STEADY;
    endproperty
    a_settle_abort: assert property (p_settle_abort)
        else $error("Settle kept running on busy bus");

    property p_rise_want;
        @(posedge clk_in) disable iff (srst_in)
        $rose(en_r) |-> $past(enable_req_in && !fast_mode_in);
    endproperty
    a_rise_want: assert property (p_rise_want)
        else $error("Enable rose without request or in fast mode");

    property p_fall_want;
        @(posedge clk_in) disable iff (srst_in)
        $fell(en_r) |-> $past(!enable_req_in || fast_mode_in);
    endproperty
    a_fall_want: assert property (p_fall_want)
        else $error("Enable fell while still wanted");

    c_enable_rise: cover property (@(posedge clk_in) disable iff (srst_in) $rose(en_r));
    c_enable_fall: cover property (@(posedge clk_in) disable iff (srst_in) $fell(en_r));
    c_settle_abort: cover property (@(posedge clk_in) disable iff (srst_in)
        state_r == repeater_pkg::ST_SETTLE ##1 !idle_both_r ##1 state_r == repeater_pkg::ST_STEADY);
    c_fast_isolate: cover property (@(posedge clk_in) disable iff (srst_in)
        $fell(en_r) && fast_mode_in);
    c_busy_hold: cover property (@(posedge clk_in) disable iff (srst_in)
        (!idle_both_r && want != en_r)[*8]);
endmodule : repeater_ctrl

// file: test/rep_model.sv
// Behavioural model of the two-channel bus repeater
`timescale 1ns/100ps
module rep_model (
    input  wire logic       en_in,    // Enable pin, may float
    input  wire logic [1:0] ext0_in,  // Port 0 external lows, bit 0 data
    input  wire logic [1:0] ext1_in,  // Port 1 external lows
    output logic      [1:0] drv0_out, // Port 0 buffered low drive
    output logic      [1:0] drv1_out  // Port 1 buffered low drive
);
    logic pwr_ok = 1'b0;
    logic en;
    initial #50 pwr_ok = 1'b1;
    // Floating pin reads as on
    assign en = (en_in !== 1'b0) && pwr_ok;
    // Only external lows count, so our own buffered low never returns
    always_comb begin
        drv1_out = en ? ext0_in : 2'h0;
        drv0_out = en ? ext1_in : 2'h0;
    end
endmodule : rep_model

// file: test/repeater_ctrl_tb.sv
// Self-checking bench for the repeater enable controller
`timescale 1ns/100ps
module repeater_ctrl_tb;
    localparam int HOLD = 3;
    logic       clk_in = 1'b0, lclk = 1'b0, srst_in = 1'b1, req = 1'b0, fast = 1'b0;
    logic       en_out, idle_out;
    logic [1:0] m0 = 2'h0, m1 = 2'h0, d0, d1, b0, b1;
    int         fails = 0, compares = 0, exp_en = 0, n, s, ln;
    assign b0 = ~(m0 | d0);
    assign b1 = ~(m1 | d1);
    initial forever #12.5 clk_in = ~clk_in;
    initial begin
        #7;
        forever #62.5 lclk = ~lclk;
    end
    repeater_ctrl #(.HOLD_CYC(HOLD), .IDLE_CYC(2)) dut (.clk_in(clk_in), .srst_in(srst_in),
        .link_clk_in(lclk), .enable_req_in(req), .fast_mode_in(fast), .bus0_data_in(b0[0]),
        .bus0_clock_in(b0[1]), .bus1_data_in(b1[0]), .bus1_clock_in(b1[1]),
        .repeater_enable_out(en_out), .bus_idle_out(idle_out));
    rep_model partner (.en_in(en_out), .ext0_in(m0), .ext1_in(m1), .drv0_out(d0),
        .drv1_out(d1));
    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #2;
    endtask : step
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic wait_idle(input logic v);
        n = 0;
        while (idle_out !== v && n < 400) begin
            step(1);
            n++;
        end
        chk("bus_idle_out", {7'h00, v}, {7'h00, idle_out});
    endtask : wait_idle
    task automatic wait_en;
        n = 0;
        while (en_out !== exp_en[0] && n < 400) begin
            step(1);
            n++;
        end
        chk("repeater_enable_out", exp_en[7:0], {7'h00, en_out});
    endtask : wait_en
    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h4157E43A));
        // Eight system cycles outlast one link period, so the link reset sync sees it
        step(8);
        srst_in = 1'b0;
        chk("enable at reset", 8'h00, {7'h00, en_out});
        // Start then stop on each isolated segment
        for (s = 0; s < 2; s++) begin
            if (s == 1) m1[0] = 1'b1; else m0[0] = 1'b1;
            step(20);
            chk("far data isolated", 8'h01, {7'h00, s ? b0[0] : b1[0]});
            m0[0] = 1'b0;
            m1[0] = 1'b0;
        end
        wait_idle(1'b1);
        req = 1'b1;
        exp_en = 1;
        wait_en();
        chk("enable latency", HOLD[7:0] + 8'h01, n[7:0]);
        // Random traffic from either port crosses and releases
        for (int i = 0; i < 6; i++) begin
            s = $urandom % 2;
            ln = $urandom % 2;
            if (s == 1) m1[ln] = 1'b1; else m0[ln] = 1'b1;
            wait_idle(1'b0);
            chk("far line low", 8'h00, {7'h00, s ? b0[ln] : b1[ln]});
            step(4 + $urandom % 20);
            m0 = 2'h0;
            m1 = 2'h0;
            step(1);
            chk("far line free", 8'h01, {7'h00, s ? b0[ln] : b1[ln]});
            wait_idle(1'b1);
            chk("enable kept", 8'h01, {7'h00, en_out});
        end
        // A change requested mid-transfer must wait for idle
        m0[1] = 1'b1;
        wait_idle(1'b0);
        req = 1'b0;
        step(40);
        chk("enable while busy", 8'h01, {7'h00, en_out});
        m0[1] = 1'b0;
        exp_en = 0;
        wait_en();
        req = 1'b1;
        fast = 1'b1;
        step(30);
        chk("fast isolates", 8'h00, {7'h00, en_out});
        fast = 1'b0;
        exp_en = 1;
        wait_en();
        fast = 1'b1;
        exp_en = 0;
        wait_en();
        chk("fast latency", HOLD[7:0] + 8'h01, n[7:0]);
        m0[0] = 1'b1;
        step(3);
        chk("isolated again", 8'h01, {7'h00, b1[0]});
        m0[0] = 1'b0;
        step(5);
        give_verdict();
    end
endmodule : repeater_ctrl_tb
